// ===== pll_core_pkg.sv
/*
  Shared constants for the PLL digital core: serial word layout, latch
  fields, output-select codes, lock timing and the register map.
  Assumes a 100 MHz core clock; the lock tick counts derive from that rate.
*/
package pll_core_pkg;
  // Core clock rate and lock thresholds
  localparam int CLK_MHZ = 100;
  localparam int LOCK_NS = 15;
  localparam int UNLOCK_NS = 25;
  localparam int ERR_W = 16;
  // Longest error that still counts as below the lock limit
  localparam logic [ERR_W-1:0] LOCK_TICKS = ERR_W'((LOCK_NS * CLK_MHZ) / 1000);
  localparam logic [ERR_W-1:0] UNLOCK_TICKS = ERR_W'((UNLOCK_NS * CLK_MHZ) / 1000);
  localparam logic [2:0] LOCK_RUN_LO = 3'h3;
  localparam logic [2:0] LOCK_RUN_HI = 3'h5;
  // Serial word and latch selection
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_FB = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
  // Field positions
  localparam int REF_DIV_LSB = 2;
  localparam int REF_DIV_W = 14;
  localparam int BACKLASH_LSB = 16;
  localparam int PRECISION_BIT = 20;
  localparam int FB_DIV_LSB = 8;
  localparam int FB_DIV_W = 13;
  localparam int OUTSEL_LSB = 4;
  localparam int PWRDN_BIT = 7;
  // Antibacklash width in core cycles per two-bit code
  localparam logic [2:0] BACKLASH_CYC0 = 3'h3;
  localparam logic [2:0] BACKLASH_CYC1 = 3'h1;
  localparam logic [2:0] BACKLASH_CYC2 = 3'h6;
  localparam logic [2:0] BACKLASH_CYC3 = 3'h3;
  // Observation output selection codes
  localparam logic [2:0] OUT_LOW = 3'h0;
  localparam logic [2:0] OUT_DLOCK = 3'h1;
  localparam logic [2:0] OUT_FBDIV = 3'h2;
  localparam logic [2:0] OUT_HIGH = 3'h3;
  localparam logic [2:0] OUT_REFDIV = 3'h4;
  localparam logic [2:0] OUT_ALOCK = 3'h5;
  // Register map (word index) and event bits
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_MASK = 2'h1;
  localparam logic [1:0] ADDR_STATE = 2'h2;
  localparam int EV_W = 3;
  localparam int EV_LOCK = 0;
  localparam int EV_UNLOCK = 1;
  localparam int EV_LOAD = 2;
endpackage

// ===== sync_edge.sv
/*
  Two-flop synchroniser for a group of pins with rising-edge detect.
  Assumes the inputs are asynchronous to i_clk and slower than it.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_edge #(
  parameter int W = 1
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Pins in, clean levels out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] last_reg;

  // Only the second and third stages feed logic; the first never does
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_reg <= '0;
      level_reg <= '0;
      last_reg <= '0;
    end
    else if (i_ce)
    begin
      meta_reg <= i_async;
      level_reg <= meta_reg;
      last_reg <= level_reg;
    end
  end

  assign o_level = level_reg;
  assign o_rise = level_reg & ~last_reg;
endmodule
`default_nettype wire

// ===== pulse_divider.sv
/*
  Programmable edge divider: one output pulse per i_ratio input ticks.
  Assumes ticks are one-cycle pulses; ratio 0 behaves as ratio 1.
*/
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
  parameter int W = 14
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_clear,
  // Input ticks and ratio
  input wire logic i_tick,
  input wire logic [W-1:0] i_ratio,
  // Divided pulse
  output logic o_pulse
);
  logic [W-1:0] cnt_reg;
  logic last;

  assign last = (i_ratio <= W'(1)) || (cnt_reg >= i_ratio - W'(1));

  // Binary count of input edges, wrap at the ratio
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_reg <= '0;
      o_pulse <= 1'b0;
    end
    else if (i_ce)
    begin
      o_pulse <= 1'b0;
      if (i_clear)
        cnt_reg <= '0;
      else if (i_tick && last)
      begin
        cnt_reg <= '0;
        o_pulse <= 1'b1;
      end
      else if (i_tick)
        cnt_reg <= cnt_reg + W'(1);
    end
  end
endmodule
`default_nettype wire

// ===== pll_core.sv
/*
  Digital core of a clock-generator PLL: three-wire serial port into
  three latches, reference and feedback dividers, phase frequency
  detector with antibacklash delay, lock detection, observation output
  and a small Avalon-MM status/interrupt block.
  Assumes all pins are asynchronous and toggle well below 50 MHz, since
  they are sampled by the 100 MHz core clock.
*/
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pll_core
  import pll_core_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Serial port and chip enable pins
  input wire logic i_serial_clock,
  input wire logic i_serial_data,
  input wire logic i_load_strobe,
  input wire logic i_chip_enable,
  // Divider inputs
  input wire logic i_reference_input,
  input wire logic i_feedback_input,
  // Charge pump drive
  output logic o_charge_pump_up,
  output logic o_charge_pump_down,
  output logic o_charge_pump_oe,
  // Observation output and open-drain analog lock
  output logic o_observation_output,
  output logic o_analog_lock_out,
  output logic o_analog_lock_oe,
  // Avalon-MM slave
  input wire logic [1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Interrupt
  output logic o_irq
);
  // Synchronised pins
  logic [5:0] pin_level;
  logic [5:0] pin_rise;
  logic sdata_lvl;
  logic ce_lvl;
  logic sclk_rise;
  logic strobe_rise;
  logic ref_rise;
  logic fb_rise;

  // Serial port and latches
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] ref_latch_reg;
  logic [WORD_W-1:0] fb_latch_reg;
  logic [WORD_W-1:0] func_latch_reg;
  logic init_load_reg;
  logic load_event;

  // Decoded fields
  logic [REF_DIV_W-1:0] ref_ratio;
  logic [FB_DIV_W-1:0] fb_ratio;
  logic [1:0] backlash_code;
  logic precision;
  logic [2:0] outsel;
  logic powered;

  // Dividers and detector
  logic ref_pulse;
  logic fb_pulse;
  logic ref_half_reg;
  logic fb_half_reg;
  logic up_reg;
  logic dn_reg;
  logic [2:0] backlash_cnt_reg;
  logic [2:0] backlash_cyc;
  logic pump_clear;
  logic evaluate;
  logic [ERR_W-1:0] err_cnt_reg;

  // Lock detection
  logic lock_reg;
  logic lock_next;
  logic [2:0] run_reg;
  logic [2:0] run_next;
  logic [2:0] run_target;

  // Register block
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] events;
  logic bus_done;
  logic status_read;

  // Pin order: data, clock, strobe, enable, reference, feedback
  sync_edge #(
    .W(6)
  ) u_pins (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async({i_feedback_input, i_reference_input, i_chip_enable,
      i_load_strobe, i_serial_clock, i_serial_data}),
    .o_level(pin_level),
    .o_rise(pin_rise)
  );

  // Data and clock share the same sync depth, so setup is kept
  assign sdata_lvl = pin_level[0];
  assign sclk_rise = pin_rise[1];
  assign strobe_rise = pin_rise[2];
  assign ce_lvl = pin_level[3];
  assign ref_rise = pin_rise[4];
  assign fb_rise = pin_rise[5];

  // Latch field decode
  assign ref_ratio = ref_latch_reg[REF_DIV_LSB +: REF_DIV_W];
  assign backlash_code = ref_latch_reg[BACKLASH_LSB +: 2];
  assign precision = ref_latch_reg[PRECISION_BIT];
  assign fb_ratio = fb_latch_reg[FB_DIV_LSB +: FB_DIV_W];
  assign outsel = func_latch_reg[OUTSEL_LSB +: 3];
  assign powered = ce_lvl && !func_latch_reg[PWRDN_BIT];

  // Serial shift, one bit per serial clock rise, first bit ends on top
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      shift_reg <= LATCH_RESET;
    else if (i_ce && sclk_rise)
      shift_reg <= {shift_reg[WORD_W-2:0], sdata_lvl};
  end

  // Transfer to one latch on the load strobe rise
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ref_latch_reg <= LATCH_RESET;
      fb_latch_reg <= LATCH_RESET;
      func_latch_reg <= LATCH_RESET;
      init_load_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      init_load_reg <= 1'b0;
      if (strobe_rise)
      begin
        case (shift_reg[1:0])
          SEL_REF: ref_latch_reg <= shift_reg;
          SEL_FB: fb_latch_reg <= shift_reg;
          SEL_FUNC: func_latch_reg <= shift_reg;
          SEL_INIT:
          begin
            // Init writes the function layout and restarts the counters
            func_latch_reg <= shift_reg;
            init_load_reg <= 1'b1;
          end
          default: func_latch_reg <= func_latch_reg;
        endcase
      end
    end
  end

  assign load_event = i_ce && strobe_rise;

  // Reference divider
  pulse_divider #(
    .W(REF_DIV_W)
  ) u_ref_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_clear(!powered || init_load_reg),
    .i_tick(ref_rise),
    .i_ratio(ref_ratio),
    .o_pulse(ref_pulse)
  );

  // Feedback divider
  pulse_divider #(
    .W(FB_DIV_W)
  ) u_fb_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_clear(!powered || init_load_reg),
    .i_tick(fb_rise),
    .i_ratio(fb_ratio),
    .o_pulse(fb_pulse)
  );

  // Half-rate copies so the divided rates are visible on a pin
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ref_half_reg <= 1'b0;
      fb_half_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      ref_half_reg <= ref_half_reg ^ ref_pulse;
      fb_half_reg <= fb_half_reg ^ fb_pulse;
    end
  end

  // Antibacklash width per code
  always_comb
  begin
    case (backlash_code)
      2'h0: backlash_cyc = BACKLASH_CYC0;
      2'h1: backlash_cyc = BACKLASH_CYC1;
      2'h2: backlash_cyc = BACKLASH_CYC2;
      2'h3: backlash_cyc = BACKLASH_CYC3;
      default: backlash_cyc = BACKLASH_CYC0;
    endcase
  end

  // Both sides active: hold for the backlash width, then release both
  assign pump_clear = up_reg && dn_reg && (backlash_cnt_reg >= backlash_cyc);
  // First cycle with both set closes one phase comparison
  assign evaluate = up_reg && dn_reg && (backlash_cnt_reg == 3'h0);

  // Phase frequency detector; a new edge wins over the release
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      backlash_cnt_reg <= 3'h0;
    end
    else if (i_ce)
    begin
      if (!powered)
      begin
        up_reg <= 1'b0;
        dn_reg <= 1'b0;
        backlash_cnt_reg <= 3'h0;
      end
      else
      begin
        up_reg <= ref_pulse || (up_reg && !pump_clear);
        dn_reg <= fb_pulse || (dn_reg && !pump_clear);
        if (pump_clear || !(up_reg && dn_reg))
          backlash_cnt_reg <= 3'h0;
        else
          backlash_cnt_reg <= backlash_cnt_reg + 3'h1;
      end
    end
  end

  // Error width in core ticks, saturating on frequency error
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      err_cnt_reg <= '0;
    else if (i_ce)
    begin
      if (!powered || evaluate)
        err_cnt_reg <= '0;
      else if ((up_reg ^ dn_reg) && (err_cnt_reg != '1))
        err_cnt_reg <= err_cnt_reg + ERR_W'(1);
    end
  end

  // Lock run target from the precision bit
  assign run_target = precision ? LOCK_RUN_HI : LOCK_RUN_LO;

  // Lock qualification per comparison
  always_comb
  begin
    lock_next = lock_reg;
    run_next = run_reg;
    if (!powered)
    begin
      lock_next = 1'b0;
      run_next = 3'h0;
    end
    else if (evaluate && lock_reg)
    begin
      if (err_cnt_reg > UNLOCK_TICKS)
      begin
        lock_next = 1'b0;
        run_next = 3'h0;
      end
    end
    else if (evaluate)
    begin
      if (err_cnt_reg <= LOCK_TICKS)
      begin
        if (run_reg + 3'h1 >= run_target)
        begin
          lock_next = 1'b1;
          run_next = 3'h0;
        end
        else
          run_next = run_reg + 3'h1;
      end
      else
        run_next = 3'h0;
    end
  end

  // Lock state
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      lock_reg <= 1'b0;
      run_reg <= 3'h0;
    end
    else if (i_ce)
    begin
      lock_reg <= lock_next;
      run_reg <= run_next;
    end
  end

  // Pin drivers; pump floats while powered down
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_charge_pump_up <= 1'b0;
      o_charge_pump_down <= 1'b0;
      o_charge_pump_oe <= 1'b0;
      o_analog_lock_out <= 1'b0;
      o_analog_lock_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      o_charge_pump_up <= up_reg && powered;
      o_charge_pump_down <= dn_reg && powered;
      o_charge_pump_oe <= powered;
      o_analog_lock_out <= 1'b0;
      // Pull low only during phase error pulses; released while quiet
      o_analog_lock_oe <= powered && (up_reg ^ dn_reg);
    end
  end

  // Observation output multiplexer
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_observation_output <= 1'b0;
    else if (i_ce)
    begin
      case (outsel)
        OUT_LOW: o_observation_output <= 1'b0;
        OUT_DLOCK: o_observation_output <= lock_reg;
        OUT_FBDIV: o_observation_output <= fb_half_reg;
        OUT_HIGH: o_observation_output <= 1'b1;
        OUT_REFDIV: o_observation_output <= ref_half_reg;
        OUT_ALOCK: o_observation_output <= !(powered && (up_reg ^ dn_reg));
        default: o_observation_output <= 1'b0;
      endcase
    end
  end

  // Avalon-MM slave: one wait cycle, completion when waitrequest low
  assign bus_done = (i_read || i_write) && !o_waitrequest;
  assign status_read = bus_done && i_read && (i_address == ADDR_STATUS);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_waitrequest <= 1'b1;
    else if (i_ce)
      o_waitrequest <= !((i_read || i_write) && o_waitrequest);
  end

  // Read data captured as waitrequest drops; unmapped reads zero
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_readdata <= 32'h00000000;
    else if (i_ce && i_read && o_waitrequest)
    begin
      case (i_address)
        ADDR_STATUS: o_readdata <= {29'h0, status_reg};
        ADDR_MASK: o_readdata <= {29'h0, mask_reg};
        ADDR_STATE: o_readdata <= {26'h0, run_reg, powered, ce_lvl, lock_reg};
        default: o_readdata <= 32'h00000000;
      endcase
    end
  end

  // Sticky events; a new event wins over the read clear
  assign events = {load_event, lock_reg && !lock_next, !lock_reg && lock_next};

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      status_reg <= '0;
      mask_reg <= '0;
      o_irq <= 1'b0;
    end
    else if (i_ce)
    begin
      status_reg <= (status_read ? '0 : status_reg) | events;
      if (bus_done && i_write && i_byteenable[0] && (i_address == ADDR_MASK))
        mask_reg <= i_writedata[EV_W-1:0];
      o_irq <= |(status_reg & mask_reg);
    end
  end
endmodule
`default_nettype wire

// ===== pll_core_properties.sv
/*
  Concurrent checks on the pll_core ports: bus handshake, readback
  zero fields, power-down pump release and open-drain lock data.
  Assumes binding to pll_core with one clock and synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pll_core_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pins and bus seen at the ports
  input wire logic i_chip_enable,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [1:0] i_address,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_irq,
  input wire logic o_charge_pump_oe,
  input wire logic o_analog_lock_out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Long enough low run to cover the pin synchroniser delay
  sequence ce_low_run;
    (!i_chip_enable) [*8];
  endsequence
  sequence req_waiting;
    (i_read || i_write) && o_waitrequest;
  endsequence
  a_pump_released: assert property (ce_low_run |-> !o_charge_pump_oe)
    else $error("pump driven while chip enable low");
  a_od_data_low: assert property (o_analog_lock_out == 1'b0)
    else $error("open-drain lock data not low");
  a_wait_answers: assert property (req_waiting |=> !o_waitrequest)
    else $error("waitrequest did not fall after request");
  a_wait_rearms: assert property ((i_read || i_write) && !o_waitrequest |=> o_waitrequest)
    else $error("waitrequest did not return high");
  a_idle_wait_high: assert property (!i_read && !i_write |=> o_waitrequest)
    else $error("waitrequest low without request");
  a_upper_bits_zero: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0)
    else $error("readdata upper bits not zero");
  a_unmapped_zero: assert property (i_read && !o_waitrequest && i_address == 2'h3
    |-> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_reset_low: assert property ($fell(i_rst) |-> !o_irq)
    else $error("irq high after reset");
endmodule
`default_nettype wire

// ===== serial_host.sv
/*
  Host model for the three-wire serial port: words go out MSB first.
  Assumes nothing of the core; the link clock rests low between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  // Serial pins toward the core
  output logic o_serial_clock,
  output logic o_serial_data,
  output logic o_load_strobe
);
  // Idle levels at time zero
  initial
  begin
    o_serial_clock = 1'b0;
    o_serial_data = 1'b0;
    o_load_strobe = 1'b0;
  end
  // One frame on an 80 ns link clock, then the load strobe
  task automatic send(input logic [23:0] w);
    // Step off the core clock edge so no pin change races the sampler
    #1;
    for (int i = 23; i >= 0; i--)
    begin
      o_serial_data = w[i];
      #40 o_serial_clock = 1'b1;
      #40 o_serial_clock = 1'b0;
    end
    #40 o_load_strobe = 1'b1;
    #80 o_load_strobe = 1'b0;
    // Released data line shows no stale level
    o_serial_data = ~w[0];
    #40;
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
/*
  Self-checking bench for pll_core: registers, latch loads, power-down
  and lock detection driven by skewed reference and feedback clocks.
  Assumes the serial_host model and the properties checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pll_core_pkg::*;
  logic i_clk, i_rst, i_chip_enable, i_reference_input, i_feedback_input;
  logic i_read, i_write, sclk, sdata, sload;
  logic [1:0] i_address;
  logic [3:0] i_byteenable;
  logic [31:0] i_writedata, o_readdata, rd;
  logic o_waitrequest, o_irq, o_observation_output, o_charge_pump_up;
  logic o_charge_pump_down, o_charge_pump_oe, o_analog_lock_out, o_analog_lock_oe;
  int errors, cmp_count, skew, ph;
  // Core under test; clock enable held on
  pll_core u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_serial_clock(sclk), .i_serial_data(sdata), .i_load_strobe(sload),
    .i_chip_enable(i_chip_enable), .i_reference_input(i_reference_input),
    .i_feedback_input(i_feedback_input), .o_charge_pump_up(o_charge_pump_up),
    .o_charge_pump_down(o_charge_pump_down), .o_charge_pump_oe(o_charge_pump_oe),
    .o_observation_output(o_observation_output), .o_analog_lock_out(o_analog_lock_out),
    .o_analog_lock_oe(o_analog_lock_oe), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq));
  serial_host u_host (.o_serial_clock(sclk), .o_serial_data(sdata), .o_load_strobe(sload));
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // 400 ns reference; feedback lags by skew core cycles
  always @(posedge i_clk)
  begin
    ph <= (ph == 39) ? 0 : ph + 1;
    i_reference_input <= ph < 20;
    i_feedback_input <= ((ph + 40 - skew) % 40) < 20;
  end
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One Avalon transfer; latency comes from waitrequest only
  task automatic bus(input logic we, input logic [1:0] a, input logic [31:0] wd);
    i_address <= a;
    i_writedata <= wd;
    i_read <= ~we;
    i_write <= we;
    @(posedge i_clk);
    while (o_waitrequest !== 1'b0) @(posedge i_clk);
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic load(input logic [23:0] w);
    u_host.send(w);
    repeat (8) @(posedge i_clk);
  endtask
  task automatic t_regs();
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    bus(1'b0, ADDR_MASK, 32'h0);
    chk("mask", 32'h0, rd);
    bus(1'b1, 2'h3, 32'hff);
    bus(1'b0, 2'h3, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_latch();
    logic [1:0] seen;
    logic prev;
    int tg;
    bus(1'b1, ADDR_MASK, 32'h4);
    load(24'h000032);
    chk("obs high", 32'h1, 32'(o_observation_output));
    chk("irq load", 32'h1, 32'(o_irq));
    bus(1'b0, ADDR_STATUS, 32'h0);
    // Aligned idle clocks gain lock while the first word goes out
    chk("status load", 32'h5, rd);
    repeat (2) @(posedge i_clk);
    chk("irq clear", 32'h0, 32'(o_irq));
    load(24'h000004);
    chk("ref latch", 32'h1, 32'(o_observation_output));
    load(24'h000031);
    chk("fb latch", 32'h1, 32'(o_observation_output));
    load(24'h000003);
    chk("init latch", 32'h0, 32'(o_observation_output));
    bus(1'b1, ADDR_MASK, 32'h0);
    load(24'h000002);
    chk("irq masked", 32'h0, 32'(o_irq));
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status masked", 32'h4, rd);
    // Analog lock level rests high while the clocks are aligned
    load(24'h000052);
    chk("alock idle", 32'h1, 32'(o_observation_output));
    // Both ratios two: divided feedback and reference toggle every 80 cycles
    load(24'h000008);
    load(24'h000201);
    for (int c = 2; c <= 4; c += 2)
    begin
      load({17'h0, c[2:0], 4'h2});
      seen = 2'h0;
      tg = 0;
      prev = o_observation_output;
      repeat (160)
      begin
        @(posedge i_clk);
        seen[o_observation_output] = 1'b1;
        tg += (o_observation_output != prev);
        prev = o_observation_output;
      end
      chk("divided toggle", 32'h3, 32'(seen));
      chk("divided rate", 32'h2, tg);
    end
  endtask
  task automatic t_power();
    load(24'h000092);
    bus(1'b0, ADDR_STATE, 32'h0);
    chk("pd bit", 32'h0, rd & 32'h4);
    chk("pd pump", 32'h0, 32'(o_charge_pump_oe));
    load(24'h000012);
    bus(1'b0, ADDR_STATE, 32'h0);
    chk("powered", 32'h4, rd & 32'h4);
    chk("pump on", 32'h1, 32'(o_charge_pump_oe));
    i_chip_enable <= 1'b0;
    repeat (10) @(posedge i_clk);
    chk("ce pump", 32'h0, 32'(o_charge_pump_oe));
    bus(1'b0, ADDR_STATE, 32'h0);
    chk("ce down", 32'h0, rd & 32'h4);
    i_chip_enable <= 1'b1;
    repeat (10) @(posedge i_clk);
  endtask
  task automatic t_lock(input logic prec);
    int up;
    int dn;
    int od;
    load({3'h0, prec, 4'h0, 14'h1, 2'h0});
    load(24'h000101);
    load(24'h000012);
    skew <= 4;
    repeat (320) @(posedge i_clk);
    chk("no lock", 32'h0, 32'(o_observation_output));
    bus(1'b0, ADDR_STATE, 32'h0);
    chk("run count", 32'h0, rd & 32'h38);
    up = 0;
    dn = 0;
    od = 0;
    repeat (40)
    begin
      @(posedge i_clk);
      up += o_charge_pump_up;
      dn += o_charge_pump_down;
      od += o_analog_lock_oe;
    end
    chk("pump dir", 32'h1, 32'(up > dn));
    // One low pulse per comparison, as wide as the four-cycle skew
    chk("lock pulse", 32'h4, od);
    bus(1'b1, ADDR_MASK, 32'h1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    while (ph != 0) @(posedge i_clk);
    skew <= 0;
    // Four aligned cycles seen by now
    repeat (140) @(posedge i_clk);
    chk("early lock", {31'h0, ~prec}, 32'(o_observation_output));
    bus(1'b0, ADDR_STATE, 32'h0);
    // Five-cycle mode still counting after four passes; three-cycle mode locked
    chk("lock run", prec ? 32'h20 : 32'h0, rd & 32'h38);
    repeat (160) @(posedge i_clk);
    chk("lock", 32'h1, 32'(o_observation_output));
    chk("irq lock", 32'h1, 32'(o_irq));
    skew <= 4;
    repeat (80) @(posedge i_clk);
    chk("unlock", 32'h0, 32'(o_observation_output));
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("lock events", 32'h3, rd);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", 32'h0, 32'(o_irq));
  endtask
  // Main sequence
  initial
  begin
    i_rst = 1'b1;
    i_chip_enable = 1'b1;
    {i_read, i_write, i_address, i_writedata} = '0;
    i_byteenable = 4'hf;
    {skew, errors, cmp_count} = '0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_regs();
    t_latch();
    t_power();
    t_lock(1'b0);
    t_lock(1'b1);
    end_sim();
  end
  // Watchdog well beyond the expected run of about 60 us
  initial
  begin
    #500000;
    errors++;
    end_sim();
  end
endmodule
bind pll_core pll_core_properties u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_chip_enable(i_chip_enable), .i_read(i_read), .i_write(i_write),
  .i_address(i_address), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_irq(o_irq), .o_charge_pump_oe(o_charge_pump_oe), .o_analog_lock_out(o_analog_lock_out));
`default_nettype wire
